// [pkg/lrtc_pkg.sv]
package lrtc_pkg;
    // ring size and bit level idle values
    localparam int unsigned LRTC_STAGES = 10;
    localparam logic LRTC_LVL_RST = 1'b0;
    localparam logic LRTC_FSET_N_RST = 1'b1;
    localparam logic LRTC_Q_RST = 1'b0;

    // clock and transfer timing
    localparam int unsigned LRTC_CLK_PERIOD_NS = 100;
    localparam int unsigned LRTC_XFER_MIN_NS = 2000;
    // least time, rounded up to whole cycles
    localparam int unsigned LRTC_XFER_CYC =
        (LRTC_XFER_MIN_NS + LRTC_CLK_PERIOD_NS - 1) / LRTC_CLK_PERIOD_NS;
    localparam int unsigned LRTC_XFER_W = $clog2(LRTC_XFER_CYC + 1);
    // the handoff cycle itself counts as the first of the hold
    localparam logic [LRTC_XFER_W-1:0] LRTC_XFER_LOAD =
        LRTC_XFER_W'(LRTC_XFER_CYC - 1);
    localparam logic [LRTC_XFER_W-1:0] LRTC_XFER_RST = '0;
endpackage

// [pkg/lrtc_latch_if.sv]
`timescale 1ns/10ps
interface lrtc_latch_if;
    logic on_p;
    logic off_ctl;
    logic force_clr_p;
    logic force_set_n;
    logic alt_set;
    logic alt_clr;
    logic rst;
    logic q;

    modport drv (
        output on_p, off_ctl, force_clr_p, force_set_n,
        output alt_set, alt_clr, rst,
        input q
    );
    modport elem (
        input on_p, off_ctl, force_clr_p, force_set_n,
        input alt_set, alt_clr, rst,
        output q
    );
endinterface // lrtc_latch_if

// [core/lrtc_latch.sv]
`timescale 1ns/10ps
module lrtc_latch (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // element controls and output
    lrtc_latch_if.elem lif
);
    import lrtc_pkg::*;

    logic q_r;
    logic q_nxt;
    logic clr_c;
    logic set_c;

    always_comb begin
        clr_c = lif.force_clr_p | lif.alt_clr | lif.rst;
        set_c = lif.on_p | lif.alt_set | (~lif.force_set_n & ~q_r);
        // feedback only survives while the off control stays high
        q_nxt = q_r & lif.off_ctl;
        if (set_c) begin
            q_nxt = 1'b1;
        end
        // clamps and reset override every set path
        if (clr_c) begin
            q_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q_r <= LRTC_Q_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign lif.q = q_r;

    ////////////////////////////////////////////////////////////////////
    property p_on_hold;
        @(posedge ref_clk) disable iff (srst)
        (lif.on_p && !clr_c) ##1 (lif.off_ctl && !clr_c) |=> q_r;
    endproperty
    a_on_hold: assert property (p_on_hold)
        else $error("latch lost state after on pulse");
    property p_off_drop;
        @(posedge ref_clk) disable iff (srst)
        (q_r && !lif.off_ctl && !set_c) |=> !q_r;
    endproperty
    a_off_drop: assert property (p_off_drop)
        else $error("latch held without off control");
    property p_force_clr;
        @(posedge ref_clk) disable iff (srst)
        lif.force_clr_p |=> !q_r;
    endproperty
    a_force_clr: assert property (p_force_clr)
        else $error("force clear ignored");
    property p_force_set;
        @(posedge ref_clk) disable iff (srst)
        (!lif.force_set_n && !q_r && !clr_c) |=> q_r;
    endproperty
    a_force_set: assert property (p_force_set)
        else $error("negative force did not set");
    property p_alt_set;
        @(posedge ref_clk) disable iff (srst)
        (lif.alt_set && !clr_c) |=> q_r;
    endproperty
    a_alt_set: assert property (p_alt_set)
        else $error("alternate set ignored");
    property p_alt_clr;
        @(posedge ref_clk) disable iff (srst)
        lif.alt_clr |=> !q_r;
    endproperty
    a_alt_clr: assert property (p_alt_clr)
        else $error("alternate clear ignored");
    property p_rst;
        @(posedge ref_clk) disable iff (srst)
        lif.rst [*2] |-> !q_r;
    endproperty
    a_rst: assert property (p_rst)
        else $error("latch set while reset high");
endmodule // lrtc_latch

// [core/lrtc_dlatch.sv]
`timescale 1ns/10ps
module lrtc_dlatch (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // controls
    input wire logic on_p,
    input wire logic off_p,
    input wire logic rst,
    // state
    output logic q
);
    import lrtc_pkg::*;

    logic q_r;
    logic q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (on_p) begin
            q_nxt = 1'b1;
        end
        // explicit off wins; dropping on does nothing
        if (off_p | rst) begin
            q_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q_r <= LRTC_Q_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

    ////////////////////////////////////////////////////////////////////
    property p_dl_hold;
        @(posedge ref_clk) disable iff (srst)
        (on_p && !off_p && !rst) ##1 (!off_p && !rst) [*3] |=> q_r;
    endproperty
    a_dl_hold: assert property (p_dl_hold)
        else $error("double latch cleared without off");
    property p_dl_off;
        @(posedge ref_clk) disable iff (srst)
        (q_r && off_p) |=> !q_r;
    endproperty
    a_dl_off: assert property (p_dl_off)
        else $error("double latch ignored off");
endmodule // lrtc_dlatch

// [core/lrtc_top.sv]
`timescale 1ns/10ps
module lrtc_top #(
    parameter int unsigned N = lrtc_pkg::LRTC_STAGES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // timing track level, low pulses step the ring
    input wire logic timing_in,
    // run control
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic ring_rst_in,
    input wire logic ring_clamp_in,
    // per stage direct force pins
    input wire logic [N-1:0] force_clr_in,
    input wire logic [N-1:0] force_set_n_in,
    // gates and run state
    output logic [N-1:0] gate_o,
    output logic run_o
);
    import lrtc_pkg::*;

    localparam int unsigned IW = (N > 1) ? $clog2(N) : 1;
    localparam int unsigned SW = 2 * N + 5;
    localparam logic [SW-1:0] SYNC_RST = {
        {N{LRTC_FSET_N_RST}}, {(N + 5){LRTC_LVL_RST}}};

    ////////////////////////////////////////////////////////////////////
    // two flop synchroniser for every pin
    logic [SW-1:0] pins_c;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync1_nxt;
    logic [SW-1:0] sync2_r;
    logic [SW-1:0] sync2_nxt;
    logic tim_d_r;
    logic tim_d_nxt;

    assign pins_c = {force_set_n_in, force_clr_in, stop_in, start_in,
        ring_clamp_in, ring_rst_in, timing_in};

    always_comb begin
        sync1_nxt = pins_c;
        sync2_nxt = sync1_r;
        tim_d_nxt = sync2_r[0];
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            tim_d_r <= LRTC_LVL_RST;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            tim_d_r <= tim_d_nxt;
        end
    end

    logic timing_s;
    logic ring_rst_s;
    logic clamp_s;
    logic start_s;
    logic stop_s;
    logic [N-1:0] fclr_s;
    logic [N-1:0] fset_n_s;
    logic fall_edge;

    assign timing_s = sync2_r[0];
    assign ring_rst_s = sync2_r[1];
    assign clamp_s = sync2_r[2];
    assign start_s = sync2_r[3];
    assign stop_s = sync2_r[4];
    assign fclr_s = sync2_r[N+4:5];
    assign fset_n_s = sync2_r[2*N+4:N+5];
    assign fall_edge = tim_d_r & ~timing_s;

    ////////////////////////////////////////////////////////////////////
    // run control: double latch needs an explicit stop or ring reset to clear
    logic run_q;
    logic run_prev_r;
    logic run_prev_nxt;
    logic run_start;
    logic ring_rst_c;

    lrtc_dlatch u_run (
        .ref_clk (ref_clk),
        .srst (srst),
        .on_p (start_s),
        .off_p (stop_s),
        .rst (ring_rst_s),
        .q (run_q)
    );

    always_comb begin
        run_prev_nxt = run_q;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run_prev_r <= LRTC_Q_RST;
        end else begin
            run_prev_r <= run_prev_nxt;
        end
    end

    assign run_start = run_q & ~run_prev_r;
    // a stopped ring is held in reset so it restarts from stage 0
    assign ring_rst_c = ring_rst_s | ~run_q;
    assign run_o = run_q;

    ////////////////////////////////////////////////////////////////////
    // stage handoff and transfer hold
    logic [N-1:0] gate;
    logic [N-1:0] rot_c;
    logic handoff;
    logic [IW-1:0] src_idx;
    logic [IW-1:0] dst_c;
    logic [LRTC_XFER_W-1:0] xfer_cnt_r;
    logic [LRTC_XFER_W-1:0] xfer_cnt_nxt;
    logic [IW-1:0] xfer_dst_r;
    logic [IW-1:0] xfer_dst_nxt;

    always_comb begin
        handoff = 1'b0;
        src_idx = '0;
        for (int i = 0; i < N; i++) begin
            if (fall_edge && gate[i]) begin
                handoff = 1'b1;
                src_idx = IW'(i);
            end
        end
        if (src_idx == IW'(N - 1)) begin
            dst_c = '0;
        end else begin
            dst_c = src_idx + 1'b1;
        end
        xfer_cnt_nxt = xfer_cnt_r;
        xfer_dst_nxt = xfer_dst_r;
        if (xfer_cnt_r != '0) begin
            xfer_cnt_nxt = xfer_cnt_r - 1'b1;
        end
        // hold sized to the fixed LRTC_XFER_MIN_NS transfer time
        if (handoff) begin
            xfer_cnt_nxt = LRTC_XFER_LOAD;
            xfer_dst_nxt = dst_c;
        end
        if (ring_rst_c || clamp_s) begin
            xfer_cnt_nxt = LRTC_XFER_RST;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            xfer_cnt_r <= LRTC_XFER_RST;
            xfer_dst_r <= '0;
        end else begin
            xfer_cnt_r <= xfer_cnt_nxt;
            xfer_dst_r <= xfer_dst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ring of latch elements
    lrtc_latch_if lif [N] ();

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_stage
            // handoff sets the next stage in the same edge the old clears;
            // a drop inside the hold still releases the held stage
            assign lif[g].on_p = (handoff && dst_c == IW'(g))
                || (!fall_edge && xfer_cnt_r != '0
                    && xfer_dst_r == IW'(g));
            assign lif[g].off_ctl = timing_s;
            assign lif[g].force_clr_p = fclr_s[g];
            assign lif[g].force_set_n = fset_n_s[g];
            assign lif[g].alt_set = (g == 0) ? run_start : 1'b0;
            assign lif[g].alt_clr = clamp_s;
            assign lif[g].rst = ring_rst_c;
            assign gate[g] = lif[g].q;

            lrtc_latch u_latch (
                .ref_clk (ref_clk),
                .srst (srst),
                .lif (lif[g])
            );
        end
    endgenerate

    assign gate_o = gate;
    assign rot_c = {gate[N-2:0], gate[N-1]};

    ////////////////////////////////////////////////////////////////////
    // checking helpers: forces may legally break the one-hot pattern
    logic quiet;
    logic forced_r;
    logic forced_nxt;

    assign quiet = !ring_rst_c && !clamp_s && !run_start
        && (fclr_s == '0) && (&fset_n_s);

    always_comb begin
        forced_nxt = forced_r;
        if ((fclr_s != '0) || !(&fset_n_s)) begin
            forced_nxt = 1'b1;
        end
        if (ring_rst_c || clamp_s) begin
            forced_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            forced_r <= 1'b0;
        end else begin
            forced_r <= forced_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_one_active;
        @(posedge ref_clk) disable iff (srst)
        (!forced_r && !$past(forced_r)) |-> $onehot0(gate);
    endproperty
    a_one_active: assert property (p_one_active)
        else $error("more than one ring stage active");
    property p_clear_on_drop;
        @(posedge ref_clk) disable iff (srst)
        (quiet && !forced_r && fall_edge && gate != '0)
            |=> ((gate & $past(gate)) == '0);
    endproperty
    a_clear_on_drop: assert property (p_clear_on_drop)
        else $error("stage kept without coincidence");
    property p_handoff;
        @(posedge ref_clk) disable iff (srst)
        (quiet && handoff && !forced_r) |=> (gate == $past(rot_c));
    endproperty
    a_handoff: assert property (p_handoff)
        else $error("handoff did not reach next stage");
    property p_hold_release;
        @(posedge ref_clk) disable iff (srst)
        (quiet && handoff && !forced_r && xfer_cnt_r != '0)
            |=> $onehot(gate);
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("held stage kept through a new drop");
    property p_xfer_hold;
        @(posedge ref_clk) disable iff (srst)
        (quiet && handoff) ##1 (quiet && !timing_s) [*8] |-> gate != '0;
    endproperty
    a_xfer_hold: assert property (p_xfer_hold)
        else $error("transfer did not hold next stage");
    property p_gate_len;
        @(posedge ref_clk) disable iff (srst)
        // a drop held past the transfer window is the source's fault
        (quiet && $past(quiet) && gate != $past(gate)
            && $past(gate) != '0
            && ($past(timing_s) || $past(xfer_cnt_r) != '0))
            |-> $past(fall_edge);
    endproperty
    a_gate_len: assert property (p_gate_len)
        else $error("gate changed between timing pulses");
    property p_wrap;
        @(posedge ref_clk) disable iff (srst)
        (quiet && handoff && gate[N-1]) |=> gate[0];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("last stage did not wrap to first");
    property p_ring_rst;
        @(posedge ref_clk) disable iff (srst)
        ring_rst_c |=> gate == '0;
    endproperty
    a_ring_rst: assert property (p_ring_rst)
        else $error("ring not cleared by reset");
    property p_start;
        @(posedge ref_clk) disable iff (srst)
        (run_start && !clamp_s && !fclr_s[0] && !ring_rst_c) |=> gate[0];
    endproperty
    a_start: assert property (p_start)
        else $error("start did not load stage 0");

    c_start: cover property (@(posedge ref_clk) disable iff (srst)
        run_start ##1 gate[0]);
    c_step: cover property (@(posedge ref_clk) disable iff (srst)
        gate[0] && handoff ##1 gate[1]);
    c_wrap: cover property (@(posedge ref_clk) disable iff (srst)
        gate[N-1] && handoff ##1 gate[0]);
    c_fast_step: cover property (@(posedge ref_clk) disable iff (srst)
        handoff && xfer_cnt_r != '0 ##1 $onehot(gate));
    c_expire: cover property (@(posedge ref_clk) disable iff (srst)
        gate != '0 && !timing_s && !fall_edge && xfer_cnt_r == '0
        ##1 gate == '0);
endmodule // lrtc_top

// [verif/lrtc_track_src.sv]
`timescale 1ns/10ps
module lrtc_track_src (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // pulse shape, read afresh at each transition
    input wire logic go,
    input wire logic [7:0] low_cyc,
    input wire logic [7:0] gap_cyc,
    // track level and a strobe on each drop
    output logic timing,
    output logic fall
);
    logic [7:0] cnt_r;

    // periodic low pulses; idle high, as a recorded track reads between spots
    always_ff @(posedge ref_clk) begin
        fall <= 1'b0;
        if (srst || !go) begin
            timing <= 1'b1;
            cnt_r <= gap_cyc;
        end else if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
        end else if (timing) begin
            timing <= 1'b0;
            fall <= 1'b1;
            cnt_r <= low_cyc;
        end else begin
            timing <= 1'b1;
            cnt_r <= gap_cyc;
        end
    end
endmodule // lrtc_track_src

// [verif/latch_ring_timing_counter_tb_top.sv]
`timescale 1ns/10ps
module latch_ring_timing_counter_tb_top;
    import lrtc_pkg::*;
    localparam int unsigned N = LRTC_STAGES;

    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic start_in = 1'b0;
    logic stop_in = 1'b0;
    logic ring_rst_in = 1'b0;
    logic ring_clamp_in = 1'b0;
    logic [N-1:0] force_clr_in = '0;
    logic [N-1:0] force_set_n_in = '1;
    logic go = 1'b0;
    logic [7:0] low_cyc = 8'h14;
    logic [7:0] gap_cyc = 8'h08;
    logic timing_in;
    logic fall;
    logic [N-1:0] gate_o;
    logic run_o;
    logic [N-1:0] exp_gate;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    integer seed = 9;

    always #50 ref_clk = ~ref_clk;

    lrtc_top #(.N(N)) lrtc_top_i (
        .ref_clk(ref_clk),
        .srst(srst),
        .timing_in(timing_in),
        .start_in(start_in),
        .stop_in(stop_in),
        .ring_rst_in(ring_rst_in),
        .ring_clamp_in(ring_clamp_in),
        .force_clr_in(force_clr_in),
        .force_set_n_in(force_set_n_in),
        .gate_o(gate_o),
        .run_o(run_o)
    );

    lrtc_track_src lrtc_track_src_i (
        .ref_clk(ref_clk),
        .srst(srst),
        .go(go),
        .low_cyc(low_cyc),
        .gap_cyc(gap_cyc),
        .timing(timing_in),
        .fall(fall)
    );

    ////////////////////////////////////////////////////////////////////
    function automatic logic [N-1:0] next_gate(input logic [N-1:0] g);
        return {g[N-2:0], g[N-1]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("mismatches %0d of %0d compares", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // pins take 3 edges through the sync flops into the latch
    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_fall;
        do begin
            @(posedge ref_clk);
            #1;
        end while (fall !== 1'b1);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            miscompares++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        check(16'(gate_o), 16'h0000);
        check(16'(run_o), 16'h0000);
        @(posedge ref_clk);
        start_in <= 1'b1;
        @(posedge ref_clk);
        start_in <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(16'(run_o), 16'h0001);
        @(posedge ref_clk);
        #1;
        check(16'(gate_o), 16'h0001);
        // random pulse shapes, ends included, across two wraps
        exp_gate = 'b1;
        @(posedge ref_clk);
        go <= 1'b1;
        for (int i = 0; i < 23; i++) begin
            wait_fall();
            check(16'(gate_o), 16'(exp_gate));
            check(16'(run_o), 16'h0001);
            exp_gate = next_gate(exp_gate);
            @(posedge ref_clk);
            if (i == 3) begin
                low_cyc <= 8'h01;
                gap_cyc <= 8'h04;
            end else if (i == 4) begin
                low_cyc <= 8'h13;
                gap_cyc <= 8'h04;
            end else begin
                low_cyc <= 8'(1 + ($unsigned($random(seed)) % 19));
                gap_cyc <= 8'(4 + ($unsigned($random(seed)) % 16));
            end
        end
        // stepping shifted the gate before the next drop
        repeat (4) @(posedge ref_clk);
        #1;
        check(16'(gate_o), 16'(exp_gate));
        // a drop outlasting the transfer hold empties the ring
        @(posedge ref_clk);
        low_cyc <= 8'h19;
        wait_fall();
        @(posedge ref_clk);
        low_cyc <= 8'h02;
        wait_fall();
        check(16'(gate_o), 16'h0000);
        @(posedge ref_clk);
        go <= 1'b0;
        // direct force set, then it holds by coincidence
        repeat (4) @(posedge ref_clk);
        force_set_n_in[5] <= 1'b0;
        @(posedge ref_clk);
        force_set_n_in[5] <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        check(16'(gate_o), 16'h0020);
        @(posedge ref_clk);
        force_clr_in[5] <= 1'b1;
        @(posedge ref_clk);
        force_clr_in[5] <= 1'b0;
        settle();
        check(16'(gate_o), 16'h0000);
        @(posedge ref_clk);
        force_set_n_in[2] <= 1'b0;
        @(posedge ref_clk);
        force_set_n_in[2] <= 1'b1;
        settle();
        check(16'(gate_o), 16'h0004);
        @(posedge ref_clk);
        ring_clamp_in <= 1'b1;
        settle();
        check(16'(gate_o), 16'h0000);
        @(posedge ref_clk);
        ring_clamp_in <= 1'b0;
        // stop clears the run latch and the ring
        force_set_n_in[7] <= 1'b0;
        @(posedge ref_clk);
        force_set_n_in[7] <= 1'b1;
        settle();
        @(posedge ref_clk);
        stop_in <= 1'b1;
        start_in <= 1'b1;
        settle();
        check(16'(run_o), 16'h0000);
        // the ring empties one edge after the run latch drops
        @(posedge ref_clk);
        #1;
        check(16'(gate_o), 16'h0000);
        @(posedge ref_clk);
        stop_in <= 1'b0;
        @(posedge ref_clk);
        start_in <= 1'b0;
        settle();
        // restart begins again at the first stage
        check(16'(run_o), 16'h0001);
        @(posedge ref_clk);
        #1;
        check(16'(gate_o), 16'h0001);
        @(posedge ref_clk);
        ring_rst_in <= 1'b1;
        settle();
        check(16'(run_o), 16'h0000);
        check(16'(gate_o), 16'h0000);
        @(posedge ref_clk);
        ring_rst_in <= 1'b0;
        settle();
        check(16'(run_o), 16'h0000);
        complete_run();
    end
endmodule // latch_ring_timing_counter_tb_top
